// ==== mfs_pkg.sv ====
`default_nettype none
package mfs_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets, low address bits)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_A   = 8'h00;
  localparam logic [7:0] SEQ_A    = 8'h04;
  localparam logic [7:0] LAYOUT_A = 8'h08;
  localparam logic [7:0] SERIAL_A = 8'h0c;
  localparam logic [7:0] STATUS_A = 8'h10;
  localparam logic [1:0] DATA_HI  = 2'h1;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_EN_B   = 0;
  localparam int CTRL_HOLD_B = 1;
  localparam int CTRL_SER_B  = 2;
  localparam int SEQ_NIB_LSB = 4;
  localparam int ENT_AV_B    = 26;

  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] LAST_RST = 4'h0;
  localparam logic [2:0] NIB_RST  = 3'h6;
  localparam logic [2:0] NIB_MIN  = 3'h2;
  localparam logic [2:0] NIB_MAX  = 3'h6;
  localparam int         SEL_N    = 16;
  localparam int         NIB_N    = 6;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LAY_ONE12_CNT = 2'h0,
    LAY_12_8      = 2'h1,
    LAY_TWO10     = 2'h2,
    LAY_ONE12     = 2'h3
  } mfs_layout_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_BUILD = 2'b11,
    ST_PUSH  = 2'b10
  } mfs_state_e;

  typedef struct packed {
    logic [2:0]  nib_cnt;
    logic [3:0]  status;
    logic [23:0] nibbles;
  } mfs_frame_s;

  typedef struct packed {
    logic        avail;
    logic        err2;
    logic        err1;
    logic [11:0] val2;
    logic [11:0] val1;
  } mfs_entry_s;

  typedef struct packed {
    logic       we;
    logic [3:0] addr;
    mfs_entry_s data;
  } mfs_wr_s;

endpackage
`default_nettype wire

// ==== mfs_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module mfs_mem (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Write port
  input  wire mfs_pkg::mfs_wr_s  wr,
  // Read port
  input  wire logic [3:0]        raddr,
  output var  mfs_pkg::mfs_entry_s rdata
);

  typedef struct packed {
    mfs_pkg::mfs_entry_s [mfs_pkg::SEL_N-1:0] ent;
    mfs_pkg::mfs_entry_s                      rd;
  } mfs_mem_s;

  mfs_mem_s mem_r;
  mfs_mem_s mem_nxt;

  always_comb
  begin
    mem_nxt    = mem_r;
    mem_nxt.rd = mem_r.ent[raddr];
    if (wr.we)
    begin
      mem_nxt.ent[wr.addr] = wr.data;
    end
  end

  // Cleared entries read as unavailable, so start-up frames carry zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_r <= '0;
    end
    else
    begin
      mem_r <= mem_nxt;
    end
  end

  assign rdata = mem_r.rd;

endmodule
`default_nettype wire

// ==== mfs_buf.sv ====
`timescale 1ns/1ps
`default_nettype none
module mfs_buf (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Filling side
  input  wire mfs_pkg::mfs_frame_s in_data,
  input  wire logic                in_valid,
  output var  logic                in_ready,
  // Draining side
  output var  mfs_pkg::mfs_frame_s out_data,
  output var  logic                out_valid,
  input  wire logic                out_ready
);

  typedef struct packed {
    mfs_pkg::mfs_frame_s d0;
    mfs_pkg::mfs_frame_s d1;
    logic                v0;
    logic                v1;
  } mfs_buf_s;

  mfs_buf_s buf_r;
  mfs_buf_s buf_nxt;

  always_comb
  begin
    buf_nxt = buf_r;
    if (buf_r.v0 && out_ready)
    begin
      buf_nxt.d0 = buf_r.d1;
      buf_nxt.v0 = buf_r.v1;
      buf_nxt.v1 = 1'b0;
    end
    if (in_valid && !buf_r.v1)
    begin
      if (!buf_nxt.v0)
      begin
        buf_nxt.d0 = in_data;
        buf_nxt.v0 = 1'b1;
      end
      else
      begin
        buf_nxt.d1 = in_data;
        buf_nxt.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      buf_r <= '0;
    end
    else
    begin
      buf_r <= buf_nxt;
    end
  end

  // Ready only from flops: full blocks even when a pop is due
  assign in_ready  = !buf_r.v1;
  assign out_data  = buf_r.d0;
  assign out_valid = buf_r.v0;

endmodule
`default_nettype wire

// ==== mfs_top.sv ====
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mfs_top (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output var  logic [31:0]         hrdata,
  output var  logic                hreadyout,
  output var  logic                hresp,
  // Frame stream to the nibble pulse generator
  output var  mfs_pkg::mfs_frame_s frame_data,
  output var  logic                frame_valid,
  input  wire logic                frame_ready
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    logic                wr_pend;
    logic [7:0]          wr_addr;
    logic [2:0]          ctrl;
    logic [3:0]          last;
    logic [2:0]          nib;
    logic [31:0]         layout;
    logic [1:0]          ser_bits;
    logic                ser_pend;
    logic [15:0]         avail;
    mfs_pkg::mfs_state_e fsm;
    logic [3:0]          sel;
    logic [3:0]          cnt;
    logic [2:0]          seq_nib;
    mfs_pkg::mfs_frame_s frame;
  } mfs_top_s;

  mfs_top_s s_r;
  mfs_top_s s_nxt;

  mfs_pkg::mfs_wr_s    mem_wr;
  mfs_pkg::mfs_entry_s ent;
  logic                buf_ready;
  logic [15:0]         seq_mask;
  logic [23:0]         nib_mask;
  logic                all_ready;
  mfs_pkg::mfs_layout_e lay;
  logic [11:0]         v1;
  logic [11:0]         v2;
  logic [23:0]         nb;
  logic                dual;

  // ---------------------------------------------------------------
  // Per-selector and per-nibble masks
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < mfs_pkg::SEL_N; gi++)
    begin : g_sel
      assign seq_mask[gi] = (4'(gi) <= s_r.last);
    end
    for (gi = 0; gi < mfs_pkg::NIB_N; gi++)
    begin : g_nib
      // Nibbles past the sequence length are sent as zero
      assign nib_mask[23-4*gi -: 4] = {4{3'(gi) < s_r.seq_nib}};
    end
  endgenerate

  assign all_ready = &(s_r.avail | ~seq_mask);
  assign lay       = mfs_pkg::mfs_layout_e'(s_r.layout[{s_r.sel, 1'b0} +: 2]);

  // ---------------------------------------------------------------
  // Nibble mapping of the fetched channel entry
  // ---------------------------------------------------------------
  always_comb
  begin
    v1   = ent.avail ? ent.val1 : 12'h000;
    v2   = ent.avail ? ent.val2 : 12'h000;
    dual = (lay == mfs_pkg::LAY_12_8) || (lay == mfs_pkg::LAY_TWO10);
    nb   = 24'h000000;
    nb[23:20] = s_r.sel;
    unique case (lay)
      mfs_pkg::LAY_ONE12_CNT:
      begin
        nb[19:16] = s_r.cnt;
        nb[15:4]  = v1;
      end
      mfs_pkg::LAY_12_8:
      begin
        nb[19:8] = v1;
        nb[7:4]  = v2[3:0];
        nb[3:0]  = v2[7:4];
      end
      mfs_pkg::LAY_TWO10:
      begin
        nb[19:12] = v1[9:2];
        nb[11:8]  = {v1[1:0], v2[1:0]};
        nb[7:4]   = v2[5:2];
        nb[3:0]   = v2[9:6];
      end
      mfs_pkg::LAY_ONE12:
      begin
        nb[19:8] = v1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.hreadyout = 1'b1;
    s_nxt.hresp     = 1'b0;
    mem_wr         = '0;

    // Framer sequencing
    unique case (s_r.fsm)
      mfs_pkg::ST_IDLE:
      begin
        if (s_r.ctrl[mfs_pkg::CTRL_EN_B])
        begin
          s_nxt.fsm = mfs_pkg::ST_FETCH;
          if (s_r.sel == 4'h0)
          begin
            s_nxt.seq_nib = s_r.nib;
          end
        end
      end
      mfs_pkg::ST_FETCH:
      begin
        s_nxt.fsm = mfs_pkg::ST_BUILD;
      end
      mfs_pkg::ST_BUILD:
      begin
        s_nxt.frame.nib_cnt = s_r.seq_nib;
        s_nxt.frame.nibbles = nb & nib_mask;
        s_nxt.frame.status[0] = ent.err1;
        s_nxt.frame.status[1] = dual & ent.err2;
        // Serial bits come from one stream, never from the entry
        s_nxt.frame.status[3:2] = s_r.ctrl[mfs_pkg::CTRL_SER_B] ?
                                  s_r.ser_bits : 2'b00;
        s_nxt.fsm = mfs_pkg::ST_PUSH;
      end
      mfs_pkg::ST_PUSH:
      begin
        if (buf_ready)
        begin
          s_nxt.fsm = mfs_pkg::ST_IDLE;
          if (s_r.ctrl[mfs_pkg::CTRL_SER_B])
          begin
            s_nxt.ser_pend = 1'b0;
          end
          if (s_r.ctrl[mfs_pkg::CTRL_HOLD_B] && !all_ready)
          begin
            s_nxt.sel = 4'h0;
          end
          else if (s_r.sel >= s_r.last)
          begin
            s_nxt.sel = 4'h0;
            // Counter moves only on wrap, so one sequence shares a tag
            s_nxt.cnt = s_r.cnt + 4'h1;
          end
          else
          begin
            s_nxt.sel = s_r.sel + 4'h1;
          end
        end
      end
    endcase

    // Bus data phase; placed after the framer so a write wins
    if (s_r.wr_pend)
    begin
      unique case (s_r.wr_addr)
        mfs_pkg::CTRL_A:
        begin
          s_nxt.ctrl = hwdata[2:0];
        end
        mfs_pkg::SEQ_A:
        begin
          s_nxt.last = hwdata[3:0];
          if (hwdata[6:4] < mfs_pkg::NIB_MIN)
          begin
            s_nxt.nib = mfs_pkg::NIB_MIN;
          end
          else if (hwdata[6:4] > mfs_pkg::NIB_MAX)
          begin
            s_nxt.nib = mfs_pkg::NIB_MAX;
          end
          else
          begin
            s_nxt.nib = hwdata[6:4];
          end
        end
        mfs_pkg::LAYOUT_A:
        begin
          s_nxt.layout = hwdata;
        end
        mfs_pkg::SERIAL_A:
        begin
          s_nxt.ser_bits = hwdata[1:0];
          s_nxt.ser_pend = 1'b1;
        end
        default:
        begin
          if (s_r.wr_addr[7:6] == mfs_pkg::DATA_HI)
          begin
            mem_wr.we   = 1'b1;
            mem_wr.addr = s_r.wr_addr[5:2];
            mem_wr.data = hwdata[26:0];
            s_nxt.avail[s_r.wr_addr[5:2]] = hwdata[mfs_pkg::ENT_AV_B];
          end
        end
      endcase
    end

    // Bus address phase; read data forwards a write in flight
    s_nxt.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready)
    begin
      s_nxt.wr_pend = hwrite;
      s_nxt.wr_addr = haddr[7:0];
      if (!hwrite)
      begin
        unique case (haddr[7:0])
          mfs_pkg::CTRL_A:   s_nxt.hrdata = {29'h0, s_nxt.ctrl};
          mfs_pkg::SEQ_A:    s_nxt.hrdata = {25'h0, s_nxt.nib, s_nxt.last};
          mfs_pkg::LAYOUT_A: s_nxt.hrdata = s_nxt.layout;
          mfs_pkg::SERIAL_A: s_nxt.hrdata = {23'h0, s_nxt.ser_pend, 6'h0,
                                             s_nxt.ser_bits};
          mfs_pkg::STATUS_A: s_nxt.hrdata = {s_nxt.avail, 7'h0, frame_valid,
                                             s_nxt.cnt, s_nxt.sel};
          default:           s_nxt.hrdata = 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_r           <= '0;
      s_r.hreadyout <= 1'b1;
      s_r.ctrl      <= mfs_pkg::CTRL_RST;
      s_r.last      <= mfs_pkg::LAST_RST;
      s_r.nib       <= mfs_pkg::NIB_RST;
      s_r.seq_nib   <= mfs_pkg::NIB_RST;
      s_r.fsm       <= mfs_pkg::ST_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign hrdata    = s_r.hrdata;
  assign hreadyout = s_r.hreadyout;
  assign hresp     = s_r.hresp;

  // ---------------------------------------------------------------
  // Channel memory and output buffer
  // ---------------------------------------------------------------
  mfs_mem u_mem (
    .clk     (clk),
    .reset_n (reset_n),
    .wr      (mem_wr),
    .raddr   (s_r.sel),
    .rdata   (ent)
  );

  // Two entries so a stall by the pulse generator drops no frame
  mfs_buf u_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_data   (s_r.frame),
    .in_valid  (s_r.fsm == mfs_pkg::ST_PUSH),
    .in_ready  (buf_ready),
    .out_data  (frame_data),
    .out_valid (frame_valid),
    .out_ready (frame_ready)
  );

endmodule
`default_nettype wire

// ==== mfs_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module mfs_top_sva (
  // Clock and reset
  input wire logic                clk,
  input wire logic                reset_n,
  // Register bus
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // Frame stream
  input wire mfs_pkg::mfs_frame_s frame_data,
  input wire logic                frame_valid,
  input wire logic                frame_ready
);
  logic       take;
  logic       rd_r;
  logic [3:0] sel_r;
  logic [2:0] nib_r;
  assign take = frame_valid && frame_ready;
  // ----
  // Last taken frame, for sequence checks; data-area read in flight, for read checks
  // ----
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_r  <= 1'b0;
      sel_r <= 4'h0;
      nib_r <= 3'h0;
    end
    else
    begin
      rd_r <= hsel && htrans[1] && hready && !hwrite && haddr[7:6] == 2'b01;
      if (take)
      begin
        sel_r <= frame_data.nibbles[23:20];
        nib_r <= frame_data.nib_cnt;
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_stall_hold;
    frame_valid && !frame_ready |=> frame_valid && $stable(frame_data);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("frame lost or changed under stall");
  property p_sel_next;
    take && frame_data.nibbles[23:20] != 4'h0 |-> frame_data.nibbles[23:20] == sel_r + 4'h1;
  endproperty
  a_sel_next: assert property (p_sel_next)
    else $error("selector out of sequence");
  property p_nib_range;
    frame_valid |-> frame_data.nib_cnt inside {[3'h2:3'h6]};
  endproperty
  a_nib_range: assert property (p_nib_range)
    else $error("data nibble count out of range");
  property p_nib_same;
    take && frame_data.nibbles[23:20] != 4'h0 |-> frame_data.nib_cnt == nib_r;
  endproperty
  a_nib_same: assert property (p_nib_same)
    else $error("nibble count changed within sequence");
  property p_short_zero;
    frame_valid && frame_data.nib_cnt == 3'h2 |-> frame_data.nibbles[15:0] == 16'h0000;
  endproperty
  a_short_zero: assert property (p_short_zero)
    else $error("unused nibbles not zero");
  property p_ready;
    hreadyout ##1 hreadyout;
  endproperty
  a_ready: assert property (p_ready)
    else $error("wait state inserted");
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_rd_zero;
    rd_r |-> hrdata == 32'h00000000;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("write-only area read nonzero");
  property p_rd_hold;
    !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
endmodule
`default_nettype wire

// ==== mfs_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mfs_rx_model (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Frame stream
  input  wire mfs_pkg::mfs_frame_s frame_data,
  input  wire logic                frame_valid,
  output var  logic                frame_ready,
  // Bench side
  input  wire logic                stall,
  output var  mfs_pkg::mfs_frame_s got,
  output var  logic                took
);
  assign frame_ready = !stall;
  // Whole frame kept; the bench checks frames in arrival order against the channel expected next
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      took <= 1'b0;
      got  <= '0;
    end
    else
    begin
      took <= frame_valid && frame_ready;
      if (frame_valid && frame_ready)
        got <= frame_data;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                clk;
  logic                reset_n;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  logic                frame_valid;
  logic                frame_ready;
  logic                stall;
  logic                took;
  logic                rel;
  logic [31:0]         q;
  mfs_pkg::mfs_frame_s frame_data;
  mfs_pkg::mfs_frame_s got;
  mfs_pkg::mfs_frame_s f;
  mfs_pkg::mfs_entry_s ent [4];
  int                  err_count;
  int                  check_count;
  int                  cyc;
  always #25 clk = ~clk;
  mfs_top u_mfs_top (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .frame_data(frame_data),
    .frame_valid(frame_valid), .frame_ready(frame_ready));
  mfs_rx_model u_mfs_rx_model (.clk(clk), .reset_n(reset_n), .frame_data(frame_data),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .stall(stall), .got(got),
    .took(took));
  // ----
  // Bus, frame and report tasks
  // ----
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    htrans <= 2'b10;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic get_fr(output mfs_pkg::mfs_frame_s fr);
    int n;
    n = 0;
    @(posedge clk);
    while (took !== 1'b1 && n < 300)
    begin
      n++;
      @(posedge clk);
    end
    chk("frame_arrived", {31'h0, took}, 32'h1);
    fr = got;
  endtask
  function automatic logic [27:0] exp_fr(input logic [1:0] lay, input logic [3:0] cnt,
                                         input mfs_pkg::mfs_entry_s e, input logic [1:0] ser);
    logic [11:0] a;
    logic [11:0] b;
    logic [23:0] n;
    a = e.avail ? e.val1 : 12'h000;
    b = e.avail ? e.val2 : 12'h000;
    case (lay)
      2'h0: n = {2'h0, lay, cnt, a, 4'h0};
      2'h1: n = {2'h0, lay, a, b[3:0], b[7:4]};
      2'h2: n = {2'h0, lay, a[9:2], a[1:0], b[1:0], b[5:2], b[9:6]};
      default: n = {2'h0, lay, a, 8'h00};
    endcase
    // Second error flag only where the layout carries two values
    exp_fr = {ser, (lay == 2'h1 || lay == 2'h2) ? e.err2 : 1'b0, e.err1, n};
  endfunction
  // Channel n uses layout n, so selector equals layout code
  task automatic cfg(input logic av2, input logic [31:0] ctrl, input logic [31:0] seq);
    ent[2].avail = av2;
    for (int i = 0; i < 4; i++)
      ahb(1'b1, 8'(8'h40 + 4 * i), {5'h00, ent[i]}, q);
    ahb(1'b1, mfs_pkg::LAYOUT_A, 32'he4, q);
    ahb(1'b1, mfs_pkg::SEQ_A, seq, q);
    ahb(1'b1, mfs_pkg::SERIAL_A, 32'h2, q);
    ahb(1'b1, mfs_pkg::CTRL_A, ctrl, q);
  endtask
  task automatic rounds(input int nr, input logic [1:0] ser);
    logic [27:0] seen;
    for (int r = 0; r < nr; r++)
      for (int s = 0; s < 4; s++)
      begin
        get_fr(f);
        seen = {f.status, f.nibbles};
        chk("frame", {4'h0, seen}, {4'h0, exp_fr(2'(s), 4'(r), ent[s], ser)});
        chk("nib_cnt", {29'h0, f.nib_cnt}, 32'h6);
      end
  endtask
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stall = 1'b0;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    ent[0] = {1'b1, 1'b1, 1'b1, 12'h000, 12'habc};
    ent[1] = {1'b1, 1'b1, 1'b0, 12'h0c5, 12'h123};
    ent[2] = {1'b1, 1'b1, 1'b1, 12'h17b, 12'h2a5};
    ent[3] = {1'b1, 1'b1, 1'b0, 12'h0ff, 12'h5e6};
    do_reset();
    ahb(1'b0, mfs_pkg::CTRL_A, 32'h0, q);
    chk("ctrl_rst", q, 32'h0);
    ahb(1'b0, mfs_pkg::SEQ_A, 32'h0, q);
    chk("seq_rst", q, 32'h60);
    ahb(1'b0, 8'h20, 32'h0, q);
    chk("unmapped", q, 32'h0);
    ahb(1'b0, 8'h44, 32'h0, q);
    chk("wo_area", q, 32'h0);
    // Stall first so both buffer entries fill before draining
    stall <= 1'b1;
    cfg(1'b1, 32'h5, 32'h63);
    ahb(1'b0, mfs_pkg::SEQ_A, 32'h0, q);
    chk("seq", q, 32'h63);
    ahb(1'b0, mfs_pkg::LAYOUT_A, 32'h0, q);
    chk("layout", q, 32'he4);
    repeat (30) @(posedge clk);
    chk("stalled_valid", {31'h0, frame_valid}, 32'h1);
    stall <= 1'b0;
    rounds(2, 2'b10);
    ahb(1'b0, mfs_pkg::SERIAL_A, 32'h0, q);
    chk("serial_used", q, 32'h2);
    do_reset();
    cfg(1'b0, 32'h1, 32'h63);
    rounds(1, 2'b00);
    ahb(1'b0, mfs_pkg::SERIAL_A, 32'h0, q);
    chk("serial_kept", q, 32'h102);
    do_reset();
    cfg(1'b0, 32'h3, 32'h23);
    for (int k = 0; k < 4; k++)
    begin
      get_fr(f);
      chk("held_sel", {28'h0, f.nibbles[23:20]}, 32'h0);
      chk("short_nib", {29'h0, f.nib_cnt}, 32'h2);
    end
    // Valid flag masked: it depends on where the framer stands
    ahb(1'b0, mfs_pkg::STATUS_A, 32'h0, q);
    chk("held_status", q & 32'hfffffeff, 32'h000b0000);
    ent[2].avail = 1'b1;
    ahb(1'b1, 8'h48, {5'h00, ent[2]}, q);
    rel = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      get_fr(f);
      if (f.nibbles[23:20] == 4'h1)
        rel = 1'b1;
    end
    chk("released_sel", {31'h0, rel}, 32'h1);
    test_done();
  end
endmodule
bind mfs_top mfs_top_sva u_mfs_top_sva (.clk(clk), .reset_n(reset_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready));
`default_nettype wire
